// File: hdl/tmf_cfg.svh
// addresses, field positions and mode codes of the timer event flags
`ifndef TMF_CFG_SVH
`define TMF_CFG_SVH
`define TMF_ADDR_W 16
`define TMF_T1_FLAGS_ADDR 16'h0036
`define TMF_T3_FLAGS_ADDR 16'h0038
`define TMF_T4_FLAGS_ADDR 16'h0039
`define TMF_IO_OFFSET 16'h0020
`define TMF_IO_MAX 16'h003F
`define TMF_EXT_BASE 16'h0060
`define TMF_FLAGS_RESET 8'h00
`define TMF_BIT_CAPTURE 5
`define TMF_BIT_MATCH_B 2
`define TMF_BIT_MATCH_A 1
`define TMF_BIT_OVERFLOW 0
`define TMF_SRC_OVERFLOW 2'h0
`define TMF_SRC_MATCH_A 2'h1
`define TMF_SRC_MATCH_B 2'h2
`define TMF_SRC_CAPTURE 2'h3
`define TMF_MODE_NORMAL 4'h0
`define TMF_MODE_CTC_CMP 4'h4
`define TMF_MODE_CTC_ICR 4'hC
`define TMF_MODE_FAST_ICR 4'hE
`define TMF_MODE_RESERVED 4'hD
`define TMF_COUNT_MAX 16'hFFFF
`define TMF_PRESC_W 10
`endif

// File: hdl/tmf_pkg.sv
// types shared by the timer event flag logic
package tmf_pkg;
  typedef struct packed {
    logic [15:0] count;
    logic [15:0] cmp_a;
    logic [15:0] cmp_b;
    logic [15:0] cap_value;
    logic [3:0] mode;
    logic [2:0] clk_sel;
    logic cap_edge;
    logic force_a;
    logic force_b;
  } tmf_tin_t;
  // order matches flag nibble: capture, match b, match a, overflow
  typedef struct packed {
    logic capture;
    logic match_b;
    logic match_a;
    logic overflow;
  } tmf_evt_t;
  typedef struct packed {
    logic pin_s1;
    logic pin_s2;
    logic pin_prev;
    logic pend_a;
    logic pend_b;
  } tmf_tev_state_t;
  typedef struct packed {
    logic [2:0][3:0] flags;
    logic [7:0] rdata;
    logic [11:0] irq;
    logic [9:0] presc;
  } tmf_top_state_t;
endpackage

// File: hdl/tmf_timer_events.sv
// event detection for one 16-bit timer: capture, compare matches, overflow
`timescale 1ns/100ps
`include "tmf_cfg.svh"
module tmf_timer_events
  import tmf_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input tmf_tin_t tin,
  input wire logic tick,
  input wire logic cap_pin,
  output tmf_evt_t evt
);
  tmf_tev_state_t q;
  tmf_tev_state_t d;
  logic icr_top;
  logic [15:0] top;
  logic at_top;
  logic edge_seen;

  function automatic logic [15:0] top_of(input tmf_tin_t t);
    case (t.mode)
      4'h1, 4'h5: top_of = 16'h00FF;
      4'h2, 4'h6: top_of = 16'h01FF;
      4'h3, 4'h7: top_of = 16'h03FF;
      4'h8, 4'hA, 4'hC, 4'hE: top_of = t.cap_value;
      4'h4, 4'h9, 4'hB, 4'hF: top_of = t.cmp_a;
      default: top_of = `TMF_COUNT_MAX;
    endcase
  endfunction

  always_comb
  begin
    d = q;
    d.pin_s1 = cap_pin;
    d.pin_s2 = q.pin_s1;
    d.pin_prev = q.pin_s2;
    // match latched on one timer tick, flagged on the next
    if (tick)
    begin
      d.pend_a = (tin.count == tin.cmp_a); // RULE6
      d.pend_b = (tin.count == tin.cmp_b); // RULE6
    end
    icr_top = (tin.mode == `TMF_MODE_CTC_ICR) || (tin.mode == `TMF_MODE_FAST_ICR);
    top = top_of(tin);
    at_top = tick && (tin.count == top);
    edge_seen = (q.pin_s2 != q.pin_prev) && (q.pin_s2 == tin.cap_edge);
    evt.capture = icr_top ? at_top : edge_seen; // RULE4 RULE5
    // force strobes never reach the match path
    evt.match_a = tick && q.pend_a; // RULE6 RULE7
    evt.match_b = tick && q.pend_b; // RULE6 RULE7
    case (tin.mode)
      `TMF_MODE_NORMAL, `TMF_MODE_CTC_CMP, `TMF_MODE_CTC_ICR:
        evt.overflow = tick && (tin.count == `TMF_COUNT_MAX); // RULE8
      4'h5, 4'h6, 4'h7, 4'hE, 4'hF:
        evt.overflow = at_top; // RULE8
      `TMF_MODE_RESERVED:
        evt.overflow = 1'b0;
      default:
        evt.overflow = tick && (tin.count == 16'h0000); // RULE8
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      q <= '0;
    else
      q <= d;
  end

  property p_capture_pin;
    @(posedge clk) disable iff (reset)
    (evt.capture && !icr_top && tin.cap_edge) |-> ($past(cap_pin, 2) && !$past(cap_pin, 3));
  endproperty
  a_capture_pin: assert property (p_capture_pin) else $error("capture without pin rise"); // RULE4

  property p_capture_top;
    @(posedge clk) disable iff (reset)
    (icr_top && tick && tin.count == tin.cap_value) |-> evt.capture;
  endproperty
  a_capture_top: assert property (p_capture_top) else $error("capture missed at top"); // RULE5

  property p_match_next;
    @(posedge clk) disable iff (reset)
    (tick && tin.count == tin.cmp_a) ##1 tick |-> evt.match_a;
  endproperty
  a_match_next: assert property (p_match_next) else $error("match a not flagged"); // RULE6

  property p_force_silent;
    @(posedge clk) disable iff (reset)
    (tin.force_b && !q.pend_b) |-> !evt.match_b;
  endproperty
  a_force_silent: assert property (p_force_silent) else $error("force set match b"); // RULE7

  property p_overflow_normal;
    @(posedge clk) disable iff (reset)
    (evt.overflow && tin.mode == `TMF_MODE_NORMAL) |-> (tin.count == `TMF_COUNT_MAX);
  endproperty
  a_overflow_normal: assert property (p_overflow_normal) else $error("overflow off max"); // RULE8

  c_capture: cover property (@(posedge clk) disable iff (reset) evt.capture);
endmodule

// File: hdl/tmf_flags.sv
// flag registers, bus decode, vector clear and requests of timers 1, 3 and 4
// Operation
// RULE1: decode data address and I/O address plus 0x20
// RULE2: extended area only by load and store
// RULE3: capture bit5, B bit2, A bit1, overflow bit0
// RULE4: capture pin event sets capture flag; the code ignores the pin in modes 0xC and 0xE
// RULE5: capture-register top reached sets capture flag; the code does so only in modes 0xC and 0xE, not in 0x8 or 0xA
// RULE6: compare flag set one tick after match
// RULE7: forced compare strobe never sets flag
// RULE8: overflow flag point follows waveform mode
// RULE9: vector execution clears its flag
// RULE10: writing one clears a flag
// RULE11: flags at 0x36, 0x38, 0x39
// RULE12: one shared prescaler, separate tap selects
// RULE13: request needs flag, enable and global enable
// RULE14: zero writes and unused bits do nothing
// RULE15: hardware set beats same-cycle clear
`timescale 1ns/100ps
`include "tmf_cfg.svh"
module tmf_flags
  import tmf_pkg::*;
#(
  parameter int NUM_TIMERS = 3
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [15:0] bus_addr,
  input wire logic bus_io,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_wdata,
  output logic [7:0] bus_rdata,
  input wire logic vec_ack,
  input wire logic [1:0] vec_timer,
  input wire logic [1:0] vec_src,
  input wire logic global_ie,
  input wire logic [7:0] t_event_mask [NUM_TIMERS],
  input wire logic presc_reset,
  input tmf_tin_t t_in [NUM_TIMERS],
  input wire logic [NUM_TIMERS-1:0] cap_pin,
  output logic [11:0] irq
);
  tmf_top_state_t q;
  tmf_top_state_t d;
  tmf_evt_t evt [NUM_TIMERS];
  logic [NUM_TIMERS-1:0] tick;
  logic [1:0] hit_idx;
  logic hit;
  logic [3:0] clr;

  function automatic logic tap_tick(input logic [2:0] sel, input logic [9:0] p);
    case (sel)
      3'h1: tap_tick = 1'b1;
      3'h2: tap_tick = &p[2:0];
      3'h3: tap_tick = &p[5:0];
      3'h4: tap_tick = &p[7:0];
      3'h5: tap_tick = &p[9:0];
      default: tap_tick = 1'b0;
    endcase
  endfunction

  // full data address, or no hit for I/O outside the short window
  function automatic logic [2:0] decode(input logic [15:0] a, input logic io);
    logic [15:0] full;
    full = io ? (a + `TMF_IO_OFFSET) : a; // RULE1
    if (io && (a > `TMF_IO_MAX || full >= `TMF_EXT_BASE)) // RULE2
      decode = 3'h0;
    else if (full == `TMF_T1_FLAGS_ADDR) // RULE11
      decode = 3'h4;
    else if (full == `TMF_T3_FLAGS_ADDR)
      decode = 3'h5;
    else if (full == `TMF_T4_FLAGS_ADDR)
      decode = 3'h6;
    else
      decode = 3'h0;
  endfunction

  function automatic logic [7:0] to_byte(input logic [3:0] f);
    logic [7:0] b;
    b = `TMF_FLAGS_RESET;
    b[`TMF_BIT_CAPTURE] = f[3]; // RULE3
    b[`TMF_BIT_MATCH_B] = f[2];
    b[`TMF_BIT_MATCH_A] = f[1];
    b[`TMF_BIT_OVERFLOW] = f[0];
    to_byte = b;
  endfunction

  function automatic logic [3:0] from_byte(input logic [7:0] b);
    from_byte = {b[`TMF_BIT_CAPTURE], b[`TMF_BIT_MATCH_B], b[`TMF_BIT_MATCH_A],
                 b[`TMF_BIT_OVERFLOW]};
  endfunction

  for (genvar t = 0; t < NUM_TIMERS; t++)
  begin : g_timer
    assign tick[t] = tap_tick(t_in[t].clk_sel, q.presc); // RULE12
    tmf_timer_events u_events (
      .clk(clk),
      .reset(reset),
      .tin(t_in[t]),
      .tick(tick[t]),
      .cap_pin(cap_pin[t]),
      .evt(evt[t])
    );
  end

  always_comb
  begin
    d = q;
    {hit, hit_idx} = decode(bus_addr, bus_io);
    d.presc = presc_reset ? 10'h000 : q.presc + 10'h001; // RULE12
    d.rdata = 8'h00;
    if (bus_rd && hit)
      d.rdata = to_byte(q.flags[hit_idx]);
    for (int t = 0; t < NUM_TIMERS; t++)
    begin
      clr = 4'h0;
      // only ones clear; zero bits and unused positions are ignored
      if (bus_wr && hit && hit_idx == t[1:0])
        clr = from_byte(bus_wdata); // RULE10 RULE14
      if (vec_ack && vec_timer == t[1:0])
        clr[vec_src] = 1'b1; // RULE9
      d.flags[t] = (q.flags[t] & ~clr) | evt[t]; // RULE15
      d.irq[t*4 +: 4] = q.flags[t] & from_byte(t_event_mask[t]) & {4{global_ie}}; // RULE13
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      q <= '0;
    else
      q <= d;
  end

  assign bus_rdata = q.rdata;
  assign irq = q.irq;

  property p_io_read;
    @(posedge clk) disable iff (reset)
    (bus_rd && bus_io && bus_addr == (`TMF_T1_FLAGS_ADDR - `TMF_IO_OFFSET))
      |=> (bus_rdata == to_byte($past(q.flags[0])));
  endproperty
  a_io_read: assert property (p_io_read) else $error("short I/O read wrong"); // RULE1

  property p_no_ext_io;
    @(posedge clk) disable iff (reset)
    (bus_rd && bus_io && bus_addr >= `TMF_IO_OFFSET) |=> (bus_rdata == 8'h00);
  endproperty
  a_no_ext_io: assert property (p_no_ext_io) else $error("I/O hit outside window"); // RULE2

  property p_reserved_zero;
    @(posedge clk) disable iff (reset)
    bus_rd |=> ((bus_rdata & 8'hD8) == 8'h00);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("unused bits read one"); // RULE3

  property p_data_read;
    @(posedge clk) disable iff (reset)
    (bus_rd && !bus_io && bus_addr == `TMF_T3_FLAGS_ADDR)
      |=> (bus_rdata == to_byte($past(q.flags[1])));
  endproperty
  a_data_read: assert property (p_data_read) else $error("timer 3 read wrong"); // RULE11

  property p_vector_clear;
    @(posedge clk) disable iff (reset)
    (vec_ack && vec_timer == 2'h2 && vec_src == `TMF_SRC_OVERFLOW && !evt[2].overflow)
      |=> !q.flags[2][0];
  endproperty
  a_vector_clear: assert property (p_vector_clear) else $error("vector left flag"); // RULE9

  property p_w1c;
    @(posedge clk) disable iff (reset)
    (bus_wr && !bus_io && bus_addr == `TMF_T4_FLAGS_ADDR && bus_wdata[`TMF_BIT_OVERFLOW]
      && !evt[2].overflow) |=> !q.flags[2][0];
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear"); // RULE10

  property p_write_zero;
    @(posedge clk) disable iff (reset)
    (bus_wr && bus_wdata == 8'h00 && !vec_ack) |=> ((q.flags[0] & $past(q.flags[0])) ==
      $past(q.flags[0]));
  endproperty
  a_write_zero: assert property (p_write_zero) else $error("zero write cleared"); // RULE14

  property p_set_wins;
    @(posedge clk) disable iff (reset)
    (evt[1].match_a && bus_wr && hit && hit_idx == 2'h1 && bus_wdata[`TMF_BIT_MATCH_A])
      |=> q.flags[1][1];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost to clear"); // RULE15

  property p_irq;
    @(posedge clk) disable iff (reset)
    (q.flags[0][3] && t_event_mask[0][`TMF_BIT_CAPTURE] && global_ie) ##1 !global_ie
      |-> irq[3] ##1 !irq[3];
  endproperty
  a_irq: assert property (p_irq) else $error("request not tied to enables"); // RULE13

  property p_tap;
    @(posedge clk) disable iff (reset)
    (t_in[2].clk_sel == 3'h2 && tick[2]) |-> (q.presc[2:0] == 3'h7);
  endproperty
  a_tap: assert property (p_tap) else $error("tap off prescaler"); // RULE12

  c_io_write: cover property (@(posedge clk) disable iff (reset) bus_wr && bus_io && hit);
  c_vector: cover property (@(posedge clk) disable iff (reset) vec_ack && q.flags[0] != 4'h0);
  c_irq: cover property (@(posedge clk) disable iff (reset) irq != 12'h000);
endmodule

// File: dv/tmf_flags_tb_top.sv
// self-checking bench for the timer event flag registers
`timescale 1ns/100ps
module tmf_flags_tb_top;
  import tmf_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [15:0] bus_addr = 16'h0000;
  logic bus_io = 1'b0;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [7:0] bus_wdata = 8'h00;
  logic [7:0] bus_rdata;
  logic vec_ack = 1'b0;
  logic [1:0] vec_timer = 2'h0;
  logic [1:0] vec_src = 2'h0;
  logic global_ie = 1'b1;
  logic [7:0] t_event_mask [3];
  logic presc_reset = 1'b0;
  tmf_tin_t t_in [3];
  logic [2:0] cap_pin = 3'h0;
  logic [11:0] irq;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;

  tmf_flags #(.NUM_TIMERS(3)) dut (
    .clk(clk), .reset(reset), .bus_addr(bus_addr), .bus_io(bus_io),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata), .vec_ack(vec_ack), .vec_timer(vec_timer),
    .vec_src(vec_src), .global_ie(global_ie), .t_event_mask(t_event_mask),
    .presc_reset(presc_reset), .t_in(t_in), .cap_pin(cap_pin), .irq(irq)
  );

  always #5 clk = ~clk;

  initial
  begin
    for (int i = 0; i < 3; i++)
    begin
      t_event_mask[i] = 8'h00;
      t_in[i] = '0;
      t_in[i].count = 16'h0100;
      t_in[i].cmp_a = 16'h0200;
      t_in[i].cmp_b = 16'h0300;
      t_in[i].cap_value = 16'h0400;
      t_in[i].cap_edge = 1'b1;
    end
  end

  task automatic tally_and_finish();
    if (miscompares == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // hang guard
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      miscompares = miscompares + 1;
      tally_and_finish();
    end
  end

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected data at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_irq(input logic [11:0] exp);
    samples_checked++;
    if (irq !== exp)
    begin
      miscompares++;
      $display("unexpected irq at %0t: got %h expected %h", $time, irq, exp);
    end
  endtask

  // read data is registered, so it is looked at one cycle after the strobe
  task automatic rd(input logic [15:0] a, input logic io, input logic [7:0] exp);
    @(negedge clk);
    bus_addr = a;
    bus_io = io;
    bus_rd = 1'b1;
    @(negedge clk);
    bus_rd = 1'b0;
    chk_byte(bus_rdata, exp);
  endtask

  task automatic wr(input logic [15:0] a, input logic io, input logic [7:0] d);
    @(negedge clk);
    bus_addr = a;
    bus_io = io;
    bus_wdata = d;
    bus_wr = 1'b1;
    @(negedge clk);
    bus_wr = 1'b0;
  endtask

  task automatic vack(input logic [1:0] t, input logic [1:0] s);
    @(negedge clk);
    vec_timer = t;
    vec_src = s;
    vec_ack = 1'b1;
    @(negedge clk);
    vec_ack = 1'b0;
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  initial
  begin
    idle(3);
    reset = 1'b0;
    rd(16'h0036, 1'b0, 8'h00);
    rd(16'h0018, 1'b1, 8'h00);
    rd(16'h0039, 1'b0, 8'h00);
    t_event_mask[0] = 8'h20;
    t_event_mask[2] = 8'h01;
    cap_pin[0] = 1'b1;
    idle(8);
    rd(16'h0036, 1'b0, 8'h20);
    chk_irq(12'h008);
    global_ie = 1'b0;
    idle(3);
    chk_irq(12'h000);
    global_ie = 1'b1;
    wr(16'h0036, 1'b0, 8'h00);
    rd(16'h0016, 1'b1, 8'h20);
    wr(16'h0016, 1'b1, 8'hDF);
    rd(16'h0036, 1'b0, 8'h20);
    wr(16'h0016, 1'b1, 8'h20);
    rd(16'h0036, 1'b0, 8'h00);
    t_in[1].count = 16'h0200;
    t_in[1].clk_sel = 3'h1;
    idle(4);
    rd(16'h0038, 1'b0, 8'h02);
    wr(16'h0038, 1'b0, 8'h02);
    rd(16'h0038, 1'b0, 8'h02);
    // let a non-matching tick drain the latched match before stopping
    t_in[1].count = 16'h0100;
    idle(2);
    t_in[1].clk_sel = 3'h0;
    idle(3);
    wr(16'h0038, 1'b0, 8'h02);
    rd(16'h0018, 1'b1, 8'h00);
    t_in[1].count = 16'h0100;
    t_in[1].clk_sel = 3'h1;
    t_in[1].force_a = 1'b1;
    t_in[1].force_b = 1'b1;
    idle(4);
    rd(16'h0018, 1'b1, 8'h00);
    t_in[1].force_a = 1'b0;
    t_in[1].force_b = 1'b0;
    t_in[1].clk_sel = 3'h0;
    t_in[2].count = 16'hFFFF;
    t_in[2].clk_sel = 3'h1;
    idle(3);
    t_in[2].clk_sel = 3'h0;
    idle(3);
    rd(16'h0039, 1'b0, 8'h01);
    chk_irq(12'h100);
    vack(2'h2, 2'h0);
    idle(2);
    rd(16'h0019, 1'b1, 8'h00);
    chk_irq(12'h000);
    // reserved mode never overflows
    t_in[2].mode = 4'hD;
    t_in[2].clk_sel = 3'h1;
    idle(4);
    rd(16'h0039, 1'b0, 8'h00);
    t_in[2].clk_sel = 3'h0;
    t_in[0].mode = 4'hC;
    t_in[0].count = 16'h0400;
    t_in[0].clk_sel = 3'h1;
    idle(3);
    t_in[0].clk_sel = 3'h0;
    idle(3);
    rd(16'h0036, 1'b0, 8'h20);
    vack(2'h0, 2'h3);
    idle(2);
    rd(16'h0036, 1'b0, 8'h00);
    wr(16'h0037, 1'b0, 8'hFF);
    rd(16'h0037, 1'b0, 8'h00);
    rd(16'h0036, 1'b1, 8'h00);
    rd(16'h0056, 1'b1, 8'h00);
    rd(16'h0076, 1'b0, 8'h00);
    // held prescaler gives no divide-by-8 tick
    t_in[2].mode = 4'h0;
    presc_reset = 1'b1;
    idle(1);
    t_in[2].clk_sel = 3'h2;
    idle(10);
    rd(16'h0039, 1'b0, 8'h00);
    presc_reset = 1'b0;
    idle(10);
    rd(16'h0039, 1'b0, 8'h01);
    t_in[2].clk_sel = 3'h0;
    idle(1);
    wr(16'h0039, 1'b0, 8'h01);
    rd(16'h0039, 1'b0, 8'h00);
    tally_and_finish();
  end
endmodule
